// ===== src/pts_pkg.sv
// Shared constants and types of the timestamp sideband block.
package pts_pkg;
    // Field widths.
    localparam int TAG_W = 16;
    localparam int STAMP_W = 80;
    localparam int LANE_W = 2;
    localparam int FILL_W = 7;
    localparam int OFS_W = 16;
    localparam int RXTS_W = 64;
    localparam int NUM_LANES = 4;
    localparam int ADDR_W = 8;
    // Tag queue shape: operation code above the tag.
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam int FIFO_W = 18;
    localparam logic [FIFO_AW:0] FIFO_PTR_STEP = 4'h1;
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ERROR = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_FILL = 8'h10;
    // Event bit positions in status and mask.
    localparam int NUM_EVENTS = 4;
    localparam int EV_WR_ERR = 0;
    localparam int EV_RD_ERR = 1;
    localparam int EV_TX_STAMP = 2;
    localparam int EV_RX_SOP = 3;
    // Control fields and reset values.
    localparam int CTRL_ONE_STEP = 0;
    localparam logic CTRL_ONE_STEP_RESET = 1'h1;
    localparam logic [NUM_EVENTS-1:0] EVENTS_RESET = 4'h0;
    localparam logic [FILL_W-1:0] FILL_RESET = 7'h00;
    localparam logic [FILL_W-1:0] FILL_MAX = 7'h7F;
    localparam logic [FILL_W-1:0] FILL_STEP = 7'h01;
    localparam logic [TAG_W-1:0] TAG_IGNORED = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Per-frame operation codes.
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_ONE_STEP = 2'h1,
        OP_TWO_STEP = 2'h2,
        OP_RESERVED = 2'h3
    } pts_op_t;
    // Write channel states, Gray coded in list order; the RESP to IDLE return flips both bits.
    typedef enum logic [1:0] {
        WS_IDLE = 2'h0,
        WS_ADDR = 2'h1,
        WS_RESP = 2'h3,
        WS_DATA = 2'h2
    } pts_wstate_t;
endpackage

// ===== src/pts_tag_fifo.sv
// Tag queue that pairs accepted frames with their later timestamps.
`timescale 1ns/100ps
module pts_tag_fifo (
    // Clock, reset and enable.
    input logic aclk,
    input logic aresetn,
    input logic ce,
    // Filling side.
    input logic push,
    input logic [pts_pkg::FIFO_W-1:0] push_data,
    output logic full,
    // Draining side.
    input logic pop,
    output logic [pts_pkg::FIFO_W-1:0] head_data,
    output logic empty
);
    logic [pts_pkg::FIFO_W-1:0] mem [pts_pkg::FIFO_DEPTH];
    logic [pts_pkg::FIFO_AW:0] wr_ptr;
    logic [pts_pkg::FIFO_AW:0] rd_ptr;
    wire do_push = ce & push & ~full;
    wire do_pop = ce & pop & ~empty;
    wire same_slot = wr_ptr[pts_pkg::FIFO_AW-1:0] == rd_ptr[pts_pkg::FIFO_AW-1:0];

    // The extra pointer bit tells a full queue from an empty one.
    assign full = same_slot & (wr_ptr[pts_pkg::FIFO_AW] != rd_ptr[pts_pkg::FIFO_AW]);
    assign empty = wr_ptr == rd_ptr;
    assign head_data = mem[rd_ptr[pts_pkg::FIFO_AW-1:0]];

    always_ff @(posedge aclk) begin
        if (do_push) begin
            mem[wr_ptr[pts_pkg::FIFO_AW-1:0]] <= push_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + pts_pkg::FIFO_PTR_STEP;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + pts_pkg::FIFO_PTR_STEP;
            end
        end
    end
endmodule // pts_tag_fifo

// ===== src/pts_top.sv
// Timestamp sideband of the Ethernet MAC with its AXI4-Lite register slave.
// Notes on behaviour
// - Sticky tag write and read errors until reset.
// - Code 00 takes no stamp, frame untouched.
// - Code 01 stamps and inserts into frame.
// - Reserved code 11 acts as no operation.
// - Tag ignored for no-operation frames.
// - Tag returned together with its timestamp.
// - Valid output marks a presented transmit stamp.
// - Returned tag equals the frame's supplied tag.
// - Transmit stamp is timer value at packet start.
// - Receive stamp valid in the SOP cycle.
// - Four 7-bit alignment fill level outputs.
`timescale 1ns/100ps
module pts_top (
    // Clock, reset and enable.
    input logic aclk,
    input logic aresetn,
    input logic ce,
    // AXI4-Lite write channels.
    input logic [pts_pkg::ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // AXI4-Lite read channels.
    input logic [pts_pkg::ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // Transmit frame acceptance.
    input logic tx_frame_accept,
    input logic [1:0] tx_stamp_operation_code,
    input logic [pts_pkg::TAG_W-1:0] tx_tag_in,
    // Transmit packet start at the capture plane.
    input logic tx_egress_sop,
    input logic [pts_pkg::LANE_W-1:0] tx_sop_lane,
    input logic [pts_pkg::STAMP_W-1:0] tx_timer,
    // One-step insertion inputs.
    input logic tx_upd_chksum_in,
    input logic [pts_pkg::OFS_W-1:0] tx_stamp_offset_in,
    input logic [pts_pkg::OFS_W-1:0] tx_chksum_offset_in,
    input logic [pts_pkg::RXTS_W-1:0] tx_rxstamp_in,
    // One-step insertion request to the frame datapath.
    output logic insert_valid,
    output logic [pts_pkg::STAMP_W-1:0] insert_stamp,
    output logic insert_upd_chksum,
    output logic [pts_pkg::OFS_W-1:0] insert_stamp_offset,
    output logic [pts_pkg::OFS_W-1:0] insert_chksum_offset,
    output logic [pts_pkg::RXTS_W-1:0] insert_rxstamp,
    // Transmit stamp result.
    output logic tx_stamp_valid,
    output logic [pts_pkg::TAG_W-1:0] tx_stamp_tag,
    output logic [pts_pkg::STAMP_W-1:0] tx_stamp,
    output logic [pts_pkg::LANE_W-1:0] tx_stamp_lane,
    // Tag queue errors.
    output logic tag_write_error,
    output logic tag_read_error,
    // Receive packet start.
    input logic rx_sop,
    input logic [pts_pkg::LANE_W-1:0] rx_sop_lane,
    input logic [pts_pkg::STAMP_W-1:0] rx_timer,
    output logic [pts_pkg::STAMP_W-1:0] rx_stamp,
    output logic [pts_pkg::LANE_W-1:0] rx_stamp_lane,
    // Lane alignment buffer activity and fill.
    input logic [pts_pkg::NUM_LANES-1:0] lane_buf_push,
    input logic [pts_pkg::NUM_LANES-1:0] lane_buf_pop,
    output logic [pts_pkg::FILL_W-1:0] lane_fill_0,
    output logic [pts_pkg::FILL_W-1:0] lane_fill_1,
    output logic [pts_pkg::FILL_W-1:0] lane_fill_2,
    output logic [pts_pkg::FILL_W-1:0] lane_fill_3,
    // Interrupt.
    output logic irq
);
    function automatic logic is_stamped(input logic [1:0] op);
        is_stamped = (op == pts_pkg::OP_ONE_STEP) || (op == pts_pkg::OP_TWO_STEP);
    endfunction

    function automatic logic is_mapped(input logic [pts_pkg::ADDR_W-1:0] a);
        is_mapped = (a == pts_pkg::ADDR_CTRL) || (a == pts_pkg::ADDR_STATUS) || (a == pts_pkg::ADDR_MASK)
            || (a == pts_pkg::ADDR_ERROR) || (a == pts_pkg::ADDR_FILL);
    endfunction

    logic one_step_en;
    logic [pts_pkg::NUM_EVENTS-1:0] irq_status;
    logic [pts_pkg::NUM_EVENTS-1:0] irq_mask;
    logic [pts_pkg::FILL_W-1:0] fill [pts_pkg::NUM_LANES];

    // Tag queue.
    logic q_full;
    logic q_empty;
    logic [pts_pkg::FIFO_W-1:0] q_head;
    wire op_stamped = is_stamped(tx_stamp_operation_code);
    // A no-operation frame still takes a slot so that egress order stays paired.
    wire [pts_pkg::TAG_W-1:0] push_tag = op_stamped ? tx_tag_in : pts_pkg::TAG_IGNORED;
    wire [pts_pkg::FIFO_W-1:0] push_word = {tx_stamp_operation_code, push_tag};
    wire [1:0] head_op = q_head[pts_pkg::FIFO_W-1:pts_pkg::TAG_W];
    wire [pts_pkg::TAG_W-1:0] head_tag = q_head[pts_pkg::TAG_W-1:0];

    pts_tag_fifo u_tag_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .push(tx_frame_accept),
        .push_data(push_word),
        .full(q_full),
        .pop(tx_egress_sop),
        .head_data(q_head),
        .empty(q_empty)
    );

    wire push_err = ce & tx_frame_accept & q_full;
    wire pop_err = ce & tx_egress_sop & q_empty;
    wire head_live = ce & tx_egress_sop & ~q_empty;
    // Codes 00 and 11 never reach the result or insertion path.
    wire stamp_event = head_live & is_stamped(head_op);
    wire one_step_event = stamp_event & (head_op == pts_pkg::OP_ONE_STEP) & one_step_en;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tag_write_error <= 1'b0;
            tag_read_error <= 1'b0;
        end else begin
            tag_write_error <= tag_write_error | push_err;
            tag_read_error <= tag_read_error | pop_err;
        end
    end

    // Transmit result: live in the SOP cycle, then the last result is held.
    logic [pts_pkg::TAG_W-1:0] tag_hold;
    logic [pts_pkg::STAMP_W-1:0] tx_stamp_hold;
    logic [pts_pkg::LANE_W-1:0] tx_lane_hold;
    assign tx_stamp_valid = stamp_event;
    assign tx_stamp_tag = stamp_event ? head_tag : tag_hold;
    assign tx_stamp = stamp_event ? tx_timer : tx_stamp_hold;
    assign tx_stamp_lane = stamp_event ? tx_sop_lane : tx_lane_hold;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tag_hold <= '0;
            tx_stamp_hold <= '0;
            tx_lane_hold <= '0;
        end else if (stamp_event) begin
            tag_hold <= head_tag;
            tx_stamp_hold <= tx_timer;
            tx_lane_hold <= tx_sop_lane;
        end
    end

    // One-step insertion request, one cycle after the packet start.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            insert_valid <= 1'b0;
            insert_stamp <= '0;
            insert_upd_chksum <= 1'b0;
            insert_stamp_offset <= '0;
            insert_chksum_offset <= '0;
            insert_rxstamp <= '0;
        end else if (ce) begin
            insert_valid <= one_step_event;
            if (one_step_event) begin
                insert_stamp <= tx_timer;
                insert_upd_chksum <= tx_upd_chksum_in;
                insert_stamp_offset <= tx_stamp_offset_in;
                insert_chksum_offset <= tx_chksum_offset_in;
                insert_rxstamp <= tx_rxstamp_in;
            end
        end
    end

    // Receive stamp follows the timer in the SOP cycle itself.
    logic [pts_pkg::STAMP_W-1:0] rx_stamp_hold;
    logic [pts_pkg::LANE_W-1:0] rx_lane_hold;
    wire rx_event = ce & rx_sop;
    assign rx_stamp = rx_event ? rx_timer : rx_stamp_hold;
    assign rx_stamp_lane = rx_event ? rx_sop_lane : rx_lane_hold;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_stamp_hold <= '0;
            rx_lane_hold <= '0;
        end else if (rx_event) begin
            rx_stamp_hold <= rx_timer;
            rx_lane_hold <= rx_sop_lane;
        end
    end

    // Alignment buffer fill, saturating so a stray pulse cannot wrap it.
    for (genvar g = 0; g < pts_pkg::NUM_LANES; g++) begin : g_lane
        wire up = lane_buf_push[g] & ~lane_buf_pop[g] & (fill[g] != pts_pkg::FILL_MAX);
        wire down = lane_buf_pop[g] & ~lane_buf_push[g] & (fill[g] != pts_pkg::FILL_RESET);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                fill[g] <= pts_pkg::FILL_RESET;
            end else if (ce & up) begin
                fill[g] <= fill[g] + pts_pkg::FILL_STEP;
            end else if (ce & down) begin
                fill[g] <= fill[g] - pts_pkg::FILL_STEP;
            end
        end
    end
    assign lane_fill_0 = fill[0];
    assign lane_fill_1 = fill[1];
    assign lane_fill_2 = fill[2];
    assign lane_fill_3 = fill[3];

    // AXI4-Lite write path.
    pts_pkg::pts_wstate_t wstate;
    pts_pkg::pts_wstate_t next_wstate;
    logic [pts_pkg::ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q;
    assign s_axi_awready = (wstate == pts_pkg::WS_IDLE) || (wstate == pts_pkg::WS_DATA);
    assign s_axi_wready = (wstate == pts_pkg::WS_IDLE) || (wstate == pts_pkg::WS_ADDR);
    assign s_axi_bvalid = wstate == pts_pkg::WS_RESP;
    assign s_axi_bresp = bresp_q;
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;

    always_comb begin
        next_wstate = wstate;
        unique case (wstate)
            pts_pkg::WS_IDLE: begin
                if (aw_hs & w_hs) begin
                    next_wstate = pts_pkg::WS_RESP;
                end else if (aw_hs) begin
                    next_wstate = pts_pkg::WS_ADDR;
                end else if (w_hs) begin
                    next_wstate = pts_pkg::WS_DATA;
                end
            end
            pts_pkg::WS_ADDR: begin
                if (w_hs) begin
                    next_wstate = pts_pkg::WS_RESP;
                end
            end
            pts_pkg::WS_DATA: begin
                if (aw_hs) begin
                    next_wstate = pts_pkg::WS_RESP;
                end
            end
            pts_pkg::WS_RESP: begin
                if (s_axi_bready) begin
                    next_wstate = pts_pkg::WS_IDLE;
                end
            end
        endcase
    end

    wire [pts_pkg::ADDR_W-1:0] wr_addr = aw_hs ? s_axi_awaddr : aw_addr_q;
    wire [31:0] wr_data = w_hs ? s_axi_wdata : w_data_q;
    wire [3:0] wr_strb = w_hs ? s_axi_wstrb : w_strb_q;
    wire commit = ce & (wstate != pts_pkg::WS_RESP) & (next_wstate == pts_pkg::WS_RESP);
    // All writable fields sit in byte lane 0, so only that strobe matters.
    wire wr_lane0 = commit & wr_strb[0];
    wire wr_ctrl = wr_lane0 & (wr_addr == pts_pkg::ADDR_CTRL);
    wire wr_status = wr_lane0 & (wr_addr == pts_pkg::ADDR_STATUS);
    wire wr_mask = wr_lane0 & (wr_addr == pts_pkg::ADDR_MASK);
    wire [pts_pkg::NUM_EVENTS-1:0] w1c = wr_status ? wr_data[pts_pkg::NUM_EVENTS-1:0] : pts_pkg::EVENTS_RESET;
    wire [pts_pkg::NUM_EVENTS-1:0] events = {rx_event, stamp_event, pop_err, push_err};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate <= pts_pkg::WS_IDLE;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bresp_q <= pts_pkg::RESP_OKAY;
        end else if (ce) begin
            wstate <= next_wstate;
            if (aw_hs) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (commit) begin
                bresp_q <= is_mapped(wr_addr) ? pts_pkg::RESP_OKAY : pts_pkg::RESP_DECERR;
            end
        end
    end

    // Registers; an event in the clearing cycle stays set.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            one_step_en <= pts_pkg::CTRL_ONE_STEP_RESET;
            irq_status <= pts_pkg::EVENTS_RESET;
            irq_mask <= pts_pkg::EVENTS_RESET;
        end else if (ce) begin
            irq_status <= (irq_status & ~w1c) | events;
            if (wr_ctrl) begin
                one_step_en <= wr_data[pts_pkg::CTRL_ONE_STEP];
            end
            if (wr_mask) begin
                irq_mask <= wr_data[pts_pkg::NUM_EVENTS-1:0];
            end
        end
    end
    assign irq = |(irq_status & irq_mask);

    // AXI4-Lite read path.
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire [pts_pkg::ADDR_W-1:0] ra = s_axi_araddr;
    wire [31:0] rd_ctrl = {31'h0000_0000, one_step_en};
    wire [31:0] rd_events_st = {28'h000_0000, irq_status};
    wire [31:0] rd_events_mk = {28'h000_0000, irq_mask};
    wire [31:0] rd_error = {30'h0000_0000, tag_read_error, tag_write_error};
    wire [31:0] rd_fill = {1'b0, fill[3], 1'b0, fill[2], 1'b0, fill[1], 1'b0, fill[0]};
    wire [31:0] rd_word = (ra == pts_pkg::ADDR_CTRL) ? rd_ctrl :
        (ra == pts_pkg::ADDR_STATUS) ? rd_events_st :
        (ra == pts_pkg::ADDR_MASK) ? rd_events_mk :
        (ra == pts_pkg::ADDR_ERROR) ? rd_error :
        (ra == pts_pkg::ADDR_FILL) ? rd_fill : pts_pkg::WORD_ZERO;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= pts_pkg::RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= is_mapped(ra) ? pts_pkg::RESP_OKAY : pts_pkg::RESP_DECERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_wr_err_set;
        ce && tx_frame_accept && q_full |=> tag_write_error;
    endproperty
    a_wr_err_set: assert property (p_wr_err_set) else $error("write error not raised");

    property p_rd_err_sticky;
        tag_read_error |=> tag_read_error [*4];
    endproperty
    a_rd_err_sticky: assert property (p_rd_err_sticky) else $error("read error dropped");

    property p_nop_silent;
        ce && tx_egress_sop && !q_empty && !is_stamped(head_op) |-> !tx_stamp_valid ##1 !insert_valid;
    endproperty
    a_nop_silent: assert property (p_nop_silent) else $error("no-operation frame stamped");

    property p_one_step;
        one_step_event |=> insert_valid && insert_stamp == $past(tx_timer)
            && insert_rxstamp == $past(tx_rxstamp_in);
    endproperty
    a_one_step: assert property (p_one_step) else $error("one-step insertion wrong");

    property p_two_step;
        ce && head_live && head_op == pts_pkg::OP_TWO_STEP |-> tx_stamp_valid ##1 !insert_valid;
    endproperty
    a_two_step: assert property (p_two_step) else $error("two-step result wrong");

    property p_tag_hold;
        tx_stamp_valid ##1 !tx_stamp_valid |-> tx_stamp_tag == $past(tx_stamp_tag)
            && tx_stamp == $past(tx_stamp);
    endproperty
    a_tag_hold: assert property (p_tag_hold) else $error("result not held");

    property p_valid_cause;
        tx_stamp_valid |-> tx_egress_sop && tx_stamp == tx_timer && tx_stamp_lane == tx_sop_lane;
    endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("stamp valid without start");

    property p_rx_same_cycle;
        ce && rx_sop |-> rx_stamp == rx_timer && rx_stamp_lane == rx_sop_lane;
    endproperty
    a_rx_same_cycle: assert property (p_rx_same_cycle) else $error("receive stamp late");

    property p_fill_up;
        ce && g_lane[0].up |=> lane_fill_0 == $past(lane_fill_0) + pts_pkg::FILL_STEP;
    endproperty
    a_fill_up: assert property (p_fill_up) else $error("lane fill did not count");

    c_two_step: cover property (tx_stamp_valid && head_op == pts_pkg::OP_TWO_STEP);
    c_one_step: cover property (insert_valid);
    c_wr_err: cover property ($rose(tag_write_error));
    c_irq: cover property ($rose(irq));
endmodule // pts_top

// ===== tb/pts_client_model.sv
// Client-side model: system timer and one-step insertion fields.
`timescale 1ns/100ps
module pts_client_model (
    // Clock.
    input wire logic aclk,
    // Timer and one-step fields.
    output logic [79:0] tx_timer,
    output logic [79:0] rx_timer,
    output logic upd_chksum,
    output logic [15:0] stamp_offset,
    output logic [15:0] chksum_offset,
    output logic [63:0] rxstamp
);
    logic [31:0] ns = 32'h0000_0000;
    // Seconds stay fixed so a short run never has to carry into them.
    always @(posedge aclk) ns <= ns + 32'h0000_0019;
    assign tx_timer = {48'h0000_0000_1234, ns};
    // The receive side runs the transparent form: sign bit zero, nanoseconds, then a fraction.
    assign rx_timer = {16'h0000, 1'h0, 15'h0000, ns, 16'h8000};
    assign upd_chksum = ns[5];
    assign stamp_offset = 16'h002C;
    assign chksum_offset = 16'h0028;
    assign rxstamp = {ns, ~ns};
endmodule // pts_client_model

// ===== tb/ptp_timestamp_port_tb.sv
// Self-checking bench of the timestamp sideband block.
`timescale 1ns/100ps
module ptp_timestamp_port_tb;
    typedef struct packed {logic [1:0] op; logic [15:0] tag; logic v; logic ins;} pts_row_t;
    pts_row_t rows [4] = '{'{2'h0, 16'h1111, 1'h0, 1'h0}, '{2'h1, 16'hA5C3, 1'h1, 1'h1},
        '{2'h2, 16'h5A3C, 1'h1, 1'h0}, '{2'h3, 16'h7777, 1'h0, 1'h0}};
    logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
    logic acc = 1'h0, egr = 1'h0, rxs = 1'h0, awr, wr, bv, arr, rv, sv, iv, werr, rerr, irq, upd;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd;
    logic [3:0] strb = 4'hF, push = 4'h0, pop = 4'h0;
    logic [1:0] op = 2'h0, lane = 2'h0, bresp, rresp, olane, rlane;
    logic [15:0] tag = 16'h0000, otag, so, co, ltag = 16'h0000;
    logic [79:0] txt, rxt, ost, ist, rst, est = 80'h0;
    logic [63:0] rxin;
    logic [6:0] f0, f1, f2, f3;
    logic [63:0] irx, erx;
    logic [32:0] eof;
    logic [15:0] iso, ico;
    logic iupd;
    int n_errors = 0, samples_checked = 0, cyc = 0;

    pts_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
        .tx_frame_accept(acc), .tx_stamp_operation_code(op), .tx_tag_in(tag), .tx_egress_sop(egr),
        .tx_sop_lane(lane), .tx_timer(txt), .tx_upd_chksum_in(upd), .tx_stamp_offset_in(so),
        .tx_chksum_offset_in(co), .tx_rxstamp_in(rxin), .insert_valid(iv), .insert_stamp(ist),
        .insert_upd_chksum(iupd), .insert_stamp_offset(iso), .insert_chksum_offset(ico), .insert_rxstamp(irx),
        .tx_stamp_valid(sv), .tx_stamp_tag(otag), .tx_stamp(ost), .tx_stamp_lane(olane), .tag_write_error(werr),
        .tag_read_error(rerr), .rx_sop(rxs), .rx_sop_lane(lane), .rx_timer(rxt), .rx_stamp(rst),
        .rx_stamp_lane(rlane), .lane_buf_push(push), .lane_buf_pop(pop), .lane_fill_0(f0), .lane_fill_1(f1),
        .lane_fill_2(f2), .lane_fill_3(f3), .irq(irq));
    pts_client_model cm (.aclk(aclk), .tx_timer(txt), .rx_timer(rxt), .upd_chksum(upd), .stamp_offset(so),
        .chksum_offset(co), .rxstamp(rxin));

    initial forever #12.5 aclk = ~aclk;
    // A hang anywhere ends the run as a failure.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [79:0] s, input logic [79:0] e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic rst_dut;
        aresetn <= 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
    endtask

    // Address and data are released independently, each on its own handshake edge.
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        bit ad = 1'b0;
        bit dd = 1'b0;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bready <= 1'h1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            ad = ad | awr;
            dd = dd | wr;
            if (ad) awv <= 1'h0;
            if (dd) wv <= 1'h0;
        end
        do @(posedge aclk); while (!bv);
        bready <= 1'h0;
        chk("bresp", bresp, 2'h0);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        ara <= a;
        arv <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (!arr);
        arv <= 1'h0;
        do @(posedge aclk); while (!rv);
        rready <= 1'h0;
        chk("rdata", rd, e);
        chk("rresp", rresp, er);
    endtask

    // Raises egress and checks the result outputs in the same cycle; the caller drops egress.
    task automatic stamp(input logic [1:0] l, input logic v, input logic [15:0] t);
        @(posedge aclk);
        acc <= 1'h0;
        egr <= 1'h1;
        lane <= l;
        @(negedge aclk);
        if (v) ltag = t;
        if (v) est = txt;
        if (v) erx = rxin;
        if (v) eof = {upd, so, co};
        chk("valid", sv, v);
        chk("tag", otag, ltag);
        chk("stamp", ost, est);
        if (v) chk("lane", olane, l);
    endtask

    initial begin
        rst_dut();
        foreach (rows[i]) begin
            @(posedge aclk);
            acc <= 1'h1;
            op <= rows[i].op;
            tag <= rows[i].tag;
            stamp(i[1:0], rows[i].v, rows[i].tag);
            @(posedge aclk);
            egr <= 1'h0;
            @(negedge aclk);
            chk("insert", iv, rows[i].ins);
            if (rows[i].ins) chk("istamp", ist, est);
            if (rows[i].ins) chk("irx", irx, erx);
            if (rows[i].ins) chk("iofs", {iupd, iso, ico}, eof);
            $display("row %0d done", i);
        end
        @(posedge aclk);
        acc <= 1'h1;
        op <= 2'h2;
        tag <= 16'hBEEF;
        @(posedge aclk);
        tag <= 16'hCAFE;
        stamp(2'h1, 1'h1, 16'hBEEF);
        stamp(2'h2, 1'h1, 16'hCAFE);
        @(posedge aclk);
        egr <= 1'h0;
        $display("ordering done");
        axw(8'h08, 32'h0000_0003);
        stamp(2'h0, 1'h0, 16'hCAFE);
        @(posedge aclk);
        egr <= 1'h0;
        @(negedge aclk);
        chk("rderr", rerr, 1'h1);
        chk("irq", irq, 1'h1);
        axw(8'h04, 32'h0000_0002);
        rdchk(8'h0C, 32'h0000_0002, 2'h0);
        rdchk(8'h04, 32'h0000_0004, 2'h0);
        chk("irq", irq, 1'h0);
        // Nine accepts overrun the eight-entry queue.
        @(posedge aclk);
        acc <= 1'h1;
        repeat (9) @(posedge aclk);
        acc <= 1'h0;
        @(negedge aclk);
        chk("wrerr", werr, 1'h1);
        $display("errors done");
        @(posedge aclk);
        rxs <= 1'h1;
        lane <= 2'h3;
        @(negedge aclk);
        chk("rxstamp", rst, rxt);
        chk("rxlane", rlane, 2'h3);
        @(posedge aclk);
        rxs <= 1'h0;
        push <= 4'hF;
        repeat (3) @(posedge aclk);
        push <= 4'h0;
        pop <= 4'h4;
        @(posedge aclk);
        pop <= 4'h0;
        @(negedge aclk);
        chk("fill0", f0, 7'h03);
        chk("fill2", f2, 7'h02);
        chk("fill1", f1, 7'h03);
        chk("fill3", f3, 7'h03);
        rdchk(8'h10, 32'h0302_0303, 2'h0);
        rdchk(8'h14, 32'h0000_0000, 2'h3);
        $display("receive and fill done");
        rst_dut();
        @(negedge aclk);
        chk("wrerr", werr, 1'h0);
        chk("rderr", rerr, 1'h0);
        rdchk(8'h00, 32'h0000_0001, 2'h0);
        rdchk(8'h08, 32'h0000_0000, 2'h0);
        $display("reset done");
        // With one-step disabled a one-step frame still returns its result but is not inserted.
        axw(8'h00, 32'h0000_0000);
        @(posedge aclk);
        acc <= 1'h1;
        op <= 2'h1;
        stamp(2'h2, 1'h1, 16'hCAFE);
        @(posedge aclk);
        egr <= 1'h0;
        @(negedge aclk);
        chk("insert", iv, 1'h0);
        $display("one-step off done");
        test_done();
    end
endmodule // ptp_timestamp_port_tb
